// [rtl/mbxwn_handler.sv]
// mailbox warning and notification handler with axi4-lite register access
//
// The AXI4-Lite register port and the register addresses were decided locally.
`default_nettype none
module mbxwn_handler (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [mbxwn_pkg::AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [mbxwn_pkg::AW-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_share_tick,
  input wire logic i_link_no_station,
  input wire logic [5:0] i_own_block_address,
  input wire logic [5:0] i_source_block_address,
  input wire logic i_interface_extension_option,
  input wire logic i_err_valid,
  input wire logic [1:0] i_err_pair,
  input wire logic [7:0] i_err_code,
  input wire logic [1:0] i_axis_stop,
  input wire logic [7:0] i_first_axis_stop_code,
  input wire logic [7:0] i_second_axis_stop_code,
  input wire logic [23:0] i_axis_state_register,
  input wire logic [23:0] i_cmd_rdata,
  output logic o_cmd_valid,
  output logic [1:0] o_cmd_pair,
  output logic [7:0] o_cmd_access_byte,
  output logic [23:0] o_cmd_wdata,
  output logic o_fault_indicator,
  output logic [5:0] o_rx_block_base,
  output logic [5:0] o_tx_block_base,
  output logic o_block_count_two
);
  import mbxwn_pkg::*;

  typedef struct packed {
    logic [NPAIR-1:0][31:0] ctrl;
    logic [NPAIR-1:0][31:0] ans;
    logic [NPAIR-1:0][7:0] status_byte;
    logic [NPAIR-1:0][23:0] rdat;
    logic [NPAIR-1:0][7:0] last_access_byte;
    mbxwn_note_t [NPAIR-1:0] note;
    logic [NPAIR-1:0][7:0] ncode;
    mbxwn_warn_t warn;
    mbxwn_scan_t scan;
    logic [1:0] idx;
    logic [2:0] sync;
    logic link_ok;
    logic established;
    logic lost;
    logic captured;
    logic ext;
    logic [5:0] own;
    logic [5:0] src;
    logic fault;
    logic stop_en;
    logic pend;
    logic [1:0] pend_pair;
    logic cmd_valid;
    logic [1:0] cmd_pair;
    logic [7:0] cmd_access_byte;
    logic [23:0] cmd_wdata;
    logic aw_full;
    logic [AW-1:0] awaddr;
    logic awready;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mbxwn_state_t;

  mbxwn_state_t q;
  mbxwn_state_t n;
  logic [1:0] last_idx;

  function automatic logic all_match(input logic [NPAIR-1:0][31:0] w, input logic [7:0] c,
                                     input logic ext);
    all_match = 1'b1;
    for (int i = 0; i < NPAIR; i++)
      if ((ext || i < 2) && w[i] != fill(c))
        all_match = 1'b0;
  endfunction

  function automatic logic fault_calc(input logic [5:0] own, input logic [5:0] src,
                                      input logic ext);
    fault_calc = (own == src) || (ext && (own == BLOCK_LAST || src == BLOCK_LAST ||
                 own == src + BLOCK_STEP || src == own + BLOCK_STEP));
  endfunction

  assign last_idx = q.ext ? IDX_EXT_LAST : IDX_BASE_LAST;

  always_comb
  begin
    logic [7:0] access_byte;
    logic [7:0] stop_code;
    logic [7:0] wcode;
    logic [1:0] i2;
    mbxwn_sel_t sel;
    access_byte = q.ctrl[q.idx][31:24];
    stop_code = '0;
    wcode = (q.warn == WARN_RESET) ? CODE_RESET : CODE_LINE;
    i2 = q.awaddr[3:2];
    sel = reg_sel(q.awaddr);
    n = q;
    n.cmd_valid = 1'b0;
    n.pend = 1'b0;
    // straps are caught once, at the first edge after reset release
    if (!q.captured)
    begin
      n.captured = 1'b1;
      n.own = i_own_block_address;
      n.src = i_source_block_address;
      n.ext = i_interface_extension_option;
      n.fault = fault_calc(i_own_block_address, i_source_block_address,
                           i_interface_extension_option);
    end
    // link state: change taken when second and third stages agree
    n.sync = {q.sync[1:0], i_link_no_station};
    if (q.sync[1] == q.sync[2])
      n.link_ok = ~q.sync[2];
    if (q.link_ok)
      n.established = 1'b1;
    if (q.established && !q.link_ok)
      n.lost = 1'b1;
    if (q.lost && n.link_ok)
    begin
      n.lost = 1'b0;
      if (q.warn == WARN_NONE)
        n.warn = WARN_LINE;
    end
    // finished command: echo its access byte with the fetched data
    if (q.pend)
    begin
      n.status_byte[q.pend_pair] = q.cmd_access_byte;
      n.rdat[q.pend_pair] = i_cmd_rdata;
    end
    if (q.scan == SCAN_IDLE && i_share_tick)
    begin
      if (q.warn != WARN_NONE)
      begin
        if (all_match(q.ctrl, wcode, q.ext))
        begin
          n.warn = WARN_NONE;
          for (int i = 0; i < NPAIR; i++)
          begin
            n.status_byte[i] = CODE_CLEAR;
            n.rdat[i] = i_axis_state_register;
            n.last_access_byte[i] = wcode;
            n.note[i] = NOTE_NONE;
          end
        end
      end
      else
      begin
        n.scan = SCAN_RUN;
        n.idx = '0;
      end
    end
    if (q.scan == SCAN_RUN)
    begin
      if ((q.note[q.idx] == NOTE_ERR && access_byte == CODE_ERR) ||
          (q.note[q.idx] == NOTE_STOP && access_byte == CODE_STOP))
      begin
        n.note[q.idx] = NOTE_NONE;
        n.status_byte[q.idx] = CODE_CLEAR;
        n.rdat[q.idx] = i_axis_state_register;
        n.last_access_byte[q.idx] = access_byte;
      end
      else if (q.note[q.idx] == NOTE_NONE && access_byte != q.last_access_byte[q.idx])
      begin
        n.last_access_byte[q.idx] = access_byte;
        n.cmd_valid = 1'b1;
        n.cmd_pair = q.idx;
        n.cmd_access_byte = access_byte;
        n.cmd_wdata = q.ctrl[q.idx][23:0];
        n.pend = 1'b1;
        n.pend_pair = q.idx;
      end
      if (q.idx == last_idx)
        n.scan = SCAN_IDLE;
      else
        n.idx = q.idx + IDX_STEP;
    end
    // events after the cancels, so a new event wins over its clear
    for (int k = 0; k < 2; k++)
    begin
      if (q.stop_en && i_axis_stop[k])
      begin
        stop_code = (k == 0) ? i_first_axis_stop_code : i_second_axis_stop_code;
        if (stop_code[7:4] == EVENT_NIBBLE)
        begin
          n.note[k] = NOTE_STOP;
          n.ncode[k] = stop_code;
        end
      end
    end
    if (i_err_valid && i_err_pair <= last_idx)
    begin
      n.note[i_err_pair] = NOTE_ERR;
      n.ncode[i_err_pair] = i_err_code;
    end
    for (int i = 0; i < NPAIR; i++)
    begin
      if (n.warn != WARN_NONE)
        n.ans[i] = fill((n.warn == WARN_RESET) ? CODE_RESET : CODE_LINE);
      else if (n.note[i] == NOTE_ERR)
        n.ans[i] = {CODE_ERR, n.ncode[i], LOW_ZERO};
      else if (n.note[i] == NOTE_STOP)
        n.ans[i] = {CODE_STOP, n.ncode[i], LOW_ZERO};
      else
        n.ans[i] = {n.status_byte[i], n.rdat[i]};
    end
    // axi4-lite write path
    if (q.awready && i_s_axi_awvalid)
    begin
      n.aw_full = 1'b1;
      n.awaddr = i_s_axi_awaddr;
    end
    if (q.wready && i_s_axi_wvalid)
    begin
      n.w_full = 1'b1;
      n.wdata = i_s_axi_wdata;
      n.wstrb = i_s_axi_wstrb;
    end
    if (q.bvalid && i_s_axi_bready)
      n.bvalid = 1'b0;
    if (q.aw_full && q.w_full && !q.bvalid)
    begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (sel == SEL_CTRL)
        for (int b = 0; b < 4; b++)
          if (q.wstrb[b])
            n.ctrl[i2][b*8 +: 8] = q.wdata[b*8 +: 8];
      if (sel == SEL_CFG && q.wstrb[0])
        n.stop_en = q.wdata[CFG_STOP_BIT];
    end
    n.awready = ~n.aw_full;
    n.wready = ~n.w_full;
    // axi4-lite read path
    if (q.rvalid && i_s_axi_rready)
      n.rvalid = 1'b0;
    if (q.arready && i_s_axi_arvalid)
    begin
      sel = reg_sel(i_s_axi_araddr);
      i2 = i_s_axi_araddr[3:2];
      n.rvalid = 1'b1;
      n.rresp = (sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      n.rdata = '0;
      unique case (sel)
        SEL_CTRL: n.rdata = q.ctrl[i2];
        SEL_ANS: n.rdata = q.ans[i2];
        SEL_CFG: n.rdata[CFG_STOP_BIT] = q.stop_en;
        SEL_STAT:
        begin
          n.rdata[STAT_WARN_LSB +: 2] = q.warn;
          n.rdata[STAT_FAULT_BIT] = q.fault;
          n.rdata[STAT_EXT_BIT] = q.ext;
          n.rdata[STAT_LINK_BIT] = q.link_ok;
          n.rdata[STAT_OWN_LSB +: 6] = q.own;
          n.rdata[STAT_SRC_LSB +: 6] = q.src;
          for (int i = 0; i < NPAIR; i++)
          begin
            n.rdata[STAT_ERR_LSB + i] = (q.note[i] == NOTE_ERR);
            n.rdata[STAT_STOP_LSB + i] = (q.note[i] == NOTE_STOP);
          end
        end
        SEL_NONE: n.rdata = '0;
      endcase
    end
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q <= '0;
      q.warn <= WARN_RESET;
      // pin taken as no-station until seen otherwise, so no false link-up after reset
      q.sync <= '1;
      q.ans <= {NPAIR{fill(CODE_RESET)}};
    end
    else
      q <= n;
  end

  assign o_s_axi_awready = q.awready;
  assign o_s_axi_wready = q.wready;
  assign o_s_axi_bvalid = q.bvalid;
  assign o_s_axi_bresp = q.bresp;
  assign o_s_axi_arready = q.arready;
  assign o_s_axi_rvalid = q.rvalid;
  assign o_s_axi_rdata = q.rdata;
  assign o_s_axi_rresp = q.rresp;
  assign o_cmd_valid = q.cmd_valid;
  assign o_cmd_pair = q.cmd_pair;
  assign o_cmd_access_byte = q.cmd_access_byte;
  assign o_cmd_wdata = q.cmd_wdata;
  assign o_fault_indicator = q.fault;
  assign o_rx_block_base = q.src;
  assign o_tx_block_base = q.own;
  assign o_block_count_two = q.ext;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_cancel_reset;
    q.scan == SCAN_IDLE && i_share_tick && q.warn == WARN_RESET &&
      all_match(q.ctrl, CODE_RESET, q.ext) && !i_err_valid && i_axis_stop == 2'h0;
  endsequence

  a_reset_fill: assert property (q.warn == WARN_RESET |-> q.ans[0] == fill(CODE_RESET) && q.ans[3] == fill(CODE_RESET)) else $error("reset fill wrong");
  a_reset_hold: assert property (q.warn == WARN_RESET && !i_share_tick |=> q.warn == WARN_RESET) else $error("reset warning dropped");
  a_reset_cancel: assert property (s_cancel_reset |=> q.warn == WARN_NONE && q.ans[0][31:24] == CODE_CLEAR && q.ans[1][31:24] == CODE_CLEAR) else $error("reset cancel failed");
  a_line_raise: assert property (q.lost && q.warn == WARN_NONE && q.sync[1] == q.sync[2] && !q.sync[2] |=> q.warn == WARN_LINE) else $error("line warning missing");
  a_line_cause: assert property ($rose(q.warn == WARN_LINE) |-> $past(q.lost)) else $error("line warning without loss");
  a_line_fill: assert property (q.warn == WARN_LINE |-> q.ans[1] == fill(CODE_LINE)) else $error("line fill wrong");
  a_reset_first: assert property (q.warn == WARN_RESET |=> q.warn != WARN_LINE) else $error("line warning over reset");
  a_err_set: assert property (i_err_valid && i_err_pair <= last_idx && q.warn == WARN_NONE |=> q.ans[$past(i_err_pair)][31:24] == CODE_ERR) else $error("error status missing");
  a_err_bytes: assert property (q.warn == WARN_NONE && q.note[0] == NOTE_ERR |-> q.ans[0][15:0] == LOW_ZERO && q.ans[0][23:16] == q.ncode[0]) else $error("error bytes wrong");
  a_err_hold: assert property (q.note[0] == NOTE_ERR && q.ctrl[0][31:24] != CODE_ERR |=> q.note[0] == NOTE_ERR) else $error("error dropped early");
  a_stop_map: assert property (q.stop_en && i_axis_stop[1] && i_second_axis_stop_code[7:4] == EVENT_NIBBLE && !i_err_valid |=> q.note[1] == NOTE_STOP) else $error("stop report missing");
  a_scan_order: assert property (q.scan == SCAN_RUN && q.idx != last_idx |=> q.scan == SCAN_RUN && q.idx == $past(q.idx) + IDX_STEP) else $error("scan order wrong");
  a_cmd_pair: assert property (o_cmd_valid |-> o_cmd_pair <= last_idx) else $error("command from inactive pair");
  a_fault_calc: assert property (q.captured |-> q.fault == (q.own == q.src ||
    (q.ext && (q.own == BLOCK_LAST || q.src == BLOCK_LAST || q.own - q.src == BLOCK_STEP ||
    q.src - q.own == BLOCK_STEP)))) else $error("fault decode wrong");
  a_fault_steady: assert property (q.captured |=> $stable(o_fault_indicator)) else $error("fault indicator moved");
  a_echo_copy: assert property (q.pend |=>
    q.status_byte[$past(q.pend_pair)] == $past(q.cmd_access_byte)) else $error("echo not copied");
endmodule // mbxwn_handler
`default_nettype wire

// [rtl/mbxwn_pkg.sv]
// constants and types of the mailbox warning and notification handler
`default_nettype none
package mbxwn_pkg;
  localparam int NPAIR = 4;
  localparam int AW = 8;
  // register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL0 = 8'h00;
  localparam logic [AW-1:0] ADDR_ANS0 = 8'h10;
  localparam logic [AW-1:0] ADDR_CONFIG = 8'h20;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h24;
  localparam logic [AW-1:0] ADDR_BANK_MASK = 8'hf0;
  localparam logic [AW-1:0] ADDR_WORD_MASK = 8'hfc;
  // config and status field positions
  localparam int CFG_STOP_BIT = 0;
  localparam int STAT_WARN_LSB = 0;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_EXT_BIT = 3;
  localparam int STAT_LINK_BIT = 4;
  localparam int STAT_OWN_LSB = 8;
  localparam int STAT_SRC_LSB = 16;
  localparam int STAT_ERR_LSB = 24;
  localparam int STAT_STOP_LSB = 28;
  // mailbox codes
  localparam logic [7:0] CODE_RESET = 8'h3f;
  localparam logic [7:0] CODE_LINE = 8'h3e;
  localparam logic [7:0] CODE_ERR = 8'h3d;
  localparam logic [7:0] CODE_STOP = 8'h3c;
  localparam logic [7:0] CODE_CLEAR = 8'h00;
  localparam logic [3:0] EVENT_NIBBLE = 4'h1;
  localparam logic [15:0] LOW_ZERO = 16'h0000;
  localparam logic [5:0] BLOCK_LAST = 6'h3f;
  localparam logic [5:0] BLOCK_STEP = 6'h01;
  localparam logic [1:0] IDX_BASE_LAST = 2'h1;
  localparam logic [1:0] IDX_EXT_LAST = 2'h3;
  localparam logic [1:0] IDX_STEP = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WARN_NONE, WARN_RESET, WARN_LINE} mbxwn_warn_t;
  typedef enum logic [1:0] {NOTE_NONE, NOTE_ERR, NOTE_STOP} mbxwn_note_t;
  typedef enum logic {SCAN_IDLE, SCAN_RUN} mbxwn_scan_t;
  typedef enum logic [2:0] {SEL_CTRL, SEL_ANS, SEL_CFG, SEL_STAT, SEL_NONE} mbxwn_sel_t;

  function automatic logic [31:0] fill(input logic [7:0] c);
    fill = {4{c}};
  endfunction

  function automatic mbxwn_sel_t reg_sel(input logic [AW-1:0] a);
    logic [AW-1:0] w;
    w = a & ADDR_WORD_MASK;
    if ((w & ADDR_BANK_MASK) == ADDR_CTRL0)
      reg_sel = SEL_CTRL;
    else if ((w & ADDR_BANK_MASK) == ADDR_ANS0)
      reg_sel = SEL_ANS;
    else if (w == ADDR_CONFIG)
      reg_sel = SEL_CFG;
    else if (w == ADDR_STATUS)
      reg_sel = SEL_STAT;
    else
      reg_sel = SEL_NONE;
  endfunction
endpackage
`default_nettype wire

// [test/mbxwn_host.sv]
// host-side model: axi4-lite master with mailbox cancel and polling procedures
`default_nettype none
module mbxwn_host (
  input wire logic i_core_clk,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [7:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  input wire logic i_bvalid,
  output logic o_bready,
  input wire logic [1:0] i_bresp,
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [7:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata} = 48'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_core_clk);
    {o_awvalid, o_wvalid, o_bready} <= 3'h7;
    o_awaddr <= a;
    o_wdata <= d;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_core_clk);
      if (o_awvalid && i_awready)
        o_awvalid <= 1'b0;
      if (o_wvalid && i_wready)
        o_wvalid <= 1'b0;
      if (i_bvalid)
        break;
    end
    r = i_bresp;
    o_bready <= 1'b0;
    if (n == 40)
      tb.timeout_hit();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_core_clk);
    {o_arvalid, o_rready} <= 2'h3;
    o_araddr <= a;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_core_clk);
      if (o_arvalid && i_arready)
        o_arvalid <= 1'b0;
      if (i_rvalid)
        break;
    end
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
    if (n == 40)
      tb.timeout_hit();
  endtask
  // fill every byte of the first np control words with code c
  task automatic cancel(input logic [7:0] c, input int np);
    logic [1:0] r;
    for (int p = 0; p < np; p++)
      wr(8'(4 * p), {4{c}}, r);
  endtask
  // poll an answer until it echoes want; with ab set, also leave on any code 3c to 3f (warning, error or stop)
  task automatic poll(input int p, input logic [7:0] want, input logic ab, output logic [31:0] d);
    logic [1:0] r;
    for (int n = 0; n < 30; n++)
    begin
      rd(8'h10 + 8'(4 * p), d, r);
      if (d[31:24] == want || (ab && d[31:26] == 6'h0f))
        return;
    end
    tb.timeout_hit();
  endtask
endmodule // mbxwn_host
`default_nettype wire

// [test/tb.sv]
// self-checking testbench of the mailbox warning and notification handler
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mbxwn_pkg::*;
  logic i_core_clk, i_nrst, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
  logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic i_s_axi_rready, i_share_tick, i_link_no_station, i_interface_extension_option;
  logic i_err_valid, o_cmd_valid, o_fault_indicator, o_block_count_two, tick_en;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, i_err_code, i_first_axis_stop_code, a;
  logic [7:0] i_second_axis_stop_code, o_cmd_access_byte;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d, e0;
  logic [3:0] i_s_axi_wstrb, cnt;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, i_err_pair, i_axis_stop, o_cmd_pair, r;
  logic [5:0] i_own_block_address, i_source_block_address, o_rx_block_base, o_tx_block_base;
  logic [5:0] nxt;
  logic [23:0] i_axis_state_register, i_cmd_rdata, o_cmd_wdata;
  logic [12:0] st;
  logic [12:0] straps[5] = '{{6'h05, 6'h05, 1'b0}, {6'h05, 6'h06, 1'b0},
    {6'h05, 6'h06, 1'b1}, {6'h3f, 6'h02, 1'b1}, {6'h02, 6'h3f, 1'b1}};
  logic [1:0] q[$];
  int seed, miscompares, cmp_count;
  mbxwn_handler mbxwn_handler_inst (.i_core_clk, .i_nrst, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_awaddr, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready,
    .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp,
    .i_share_tick, .i_link_no_station, .i_own_block_address, .i_source_block_address,
    .i_interface_extension_option, .i_err_valid, .i_err_pair, .i_err_code, .i_axis_stop,
    .i_first_axis_stop_code, .i_second_axis_stop_code, .i_axis_state_register, .i_cmd_rdata,
    .o_cmd_valid, .o_cmd_pair, .o_cmd_access_byte, .o_cmd_wdata, .o_fault_indicator,
    .o_rx_block_base, .o_tx_block_base, .o_block_count_two);
  mbxwn_host mbxwn_host_inst (.i_core_clk, .o_awvalid(i_s_axi_awvalid),
    .i_awready(o_s_axi_awready), .o_awaddr(i_s_axi_awaddr), .o_wvalid(i_s_axi_wvalid),
    .i_wready(o_s_axi_wready), .o_wdata(i_s_axi_wdata), .i_bvalid(o_s_axi_bvalid),
    .o_bready(i_s_axi_bready), .i_bresp(o_s_axi_bresp), .o_arvalid(i_s_axi_arvalid),
    .i_arready(o_s_axi_arready), .o_araddr(i_s_axi_araddr), .i_rvalid(o_s_axi_rvalid),
    .o_rready(i_s_axi_rready), .i_rdata(o_s_axi_rdata), .i_rresp(o_s_axi_rresp));
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // sharing cycle tick every 16 clocks, and a record of the command order
  always @(posedge i_core_clk)
  begin
    cnt <= cnt + 4'h1;
    i_share_tick <= tick_en && cnt == 4'h7;
    if (o_cmd_valid)
      q.push_back(o_cmd_pair);
  end
  function automatic logic fault_exp(input logic [5:0] o, input logic [5:0] s, input logic x);
    return o == s || (x && (o == 6'h3f || s == 6'h3f || o + 6'h1 == s || s + 6'h1 == o));
  endfunction
  function automatic logic [31:0] note(input logic [7:0] s, input logic [7:0] c);
    return {s, c, 16'h0000};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timeout_hit();
    miscompares++;
    stop_test();
  endtask
  task automatic rst(input logic [5:0] o, input logic [5:0] s, input logic x);
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    {i_own_block_address, i_source_block_address, i_interface_extension_option} <= {o, s, x};
    repeat (4) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic ans(input int p, input logic [31:0] e);
    mbxwn_host_inst.rd(ADDR_ANS0 + 8'(4 * p), d, r);
    chk("answer", d, e);
  endtask
  task automatic ev(input logic e, input logic [1:0] sp, input logic [1:0] p, input logic [7:0] c);
    @(posedge i_core_clk);
    {i_err_valid, i_axis_stop, i_err_pair, i_err_code} <= {e, sp, p, c};
    {i_first_axis_stop_code, i_second_axis_stop_code} <= {c, c};
    @(posedge i_core_clk);
    {i_err_valid, i_axis_stop} <= 3'h0;
  endtask
  // write pairs from the top down in one sharing cycle, then check the processing order
  task automatic order(input int n);
    logic [7:0] b;
    logic [31:0] w;
    logic [31:0] wl;
    tick_en <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    q.delete();
    i_cmd_rdata <= 24'($random(seed));
    for (int p = n - 1; p >= 0; p--)
    begin
      nxt = nxt + 6'h01;
      b = {2'b01, nxt};
      w = {b, 24'($random(seed))};
      if (p == n - 1)
        wl = w;
      mbxwn_host_inst.wr(ADDR_CTRL0 + 8'(4 * p), w, r);
    end
    tick_en <= 1'b1;
    mbxwn_host_inst.poll(0, b, 1'b1, d);
    repeat (8) @(posedge i_core_clk);
    e0 = {b, i_cmd_rdata};
    chk("echo", d, e0);
    chk("count", 32'(q.size()), 32'(n));
    foreach (q[k])
      chk("order", 32'(q[k]), 32'(k));
    // the highest pair goes last, so its command stays on the command outputs
    chk("last command", {o_cmd_access_byte, o_cmd_wdata}, wl);
  endtask
  initial
  begin
    {seed, miscompares, cmp_count} = {32'd97309, 32'd0, 32'd0};
    {cnt, nxt, tick_en, i_nrst, i_share_tick, i_link_no_station} = 14'h0008;
    i_s_axi_wstrb = 4'hf;
    {i_own_block_address, i_source_block_address, i_interface_extension_option} = 13'h0;
    {i_err_valid, i_err_pair, i_err_code, i_axis_stop} = 13'h0;
    {i_first_axis_stop_code, i_second_axis_stop_code, i_cmd_rdata} = 40'h0;
    i_axis_state_register = 24'($random(seed));
    for (int k = 0; k < 8; k++)
    begin
      st = k < 5 ? straps[k] : 13'($random(seed));
      rst(st[12:7], st[6:1], st[0]);
      chk("fault", 32'(o_fault_indicator), 32'(fault_exp(st[12:7], st[6:1], st[0])));
      chk("bases", 32'({o_block_count_two, o_rx_block_base, o_tx_block_base}),
        32'({st[0], st[6:1], st[12:7]}));
    end
    rst(6'h04, 6'h08, 1'b0);
    for (int p = 0; p < 4; p++)
      ans(p, {4{CODE_RESET}});
    tick_en <= 1'b0;
    mbxwn_host_inst.cancel(CODE_RESET, 2);
    repeat (20) @(posedge i_core_clk);
    ans(0, {4{CODE_RESET}});
    tick_en <= 1'b1;
    mbxwn_host_inst.poll(0, CODE_CLEAR, 1'b0, d);
    chk("reset cancel", d, {CODE_CLEAR, i_axis_state_register});
    order(2);
    mbxwn_host_inst.rd(8'h40, d, r);
    chk("resp", 32'(r), 32'(RESP_SLVERR));
    mbxwn_host_inst.wr(8'h40, 32'h0, r);
    chk("write resp", 32'(r), 32'(RESP_SLVERR));
    a = 8'($random(seed));
    ev(1'b1, 2'b00, 2'h1, a);
    ans(1, note(CODE_ERR, a));
    ans(0, e0);
    mbxwn_host_inst.wr(ADDR_CTRL0 + 8'h04, {CODE_ERR, 24'h0}, r);
    mbxwn_host_inst.poll(1, CODE_CLEAR, 1'b0, d);
    chk("error cancel", d, {CODE_CLEAR, i_axis_state_register});
    a = {4'h1, 4'($random(seed))};
    ev(1'b0, 2'b10, 2'h0, a);
    ans(1, {CODE_CLEAR, i_axis_state_register});
    mbxwn_host_inst.wr(ADDR_CONFIG, 32'h1, r);
    chk("config resp", 32'(r), 32'(RESP_OKAY));
    mbxwn_host_inst.rd(ADDR_CONFIG, d, r);
    chk("config", d, 32'h1);
    ev(1'b0, 2'b01, 2'h0, 8'h25);
    ans(0, e0);
    ev(1'b0, 2'b11, 2'h0, a);
    ans(0, note(CODE_STOP, a));
    ans(1, note(CODE_STOP, a));
    mbxwn_host_inst.wr(ADDR_CTRL0, {CODE_STOP, 24'h0}, r);
    mbxwn_host_inst.wr(ADDR_CTRL0 + 8'h04, {CODE_STOP, 24'h0}, r);
    mbxwn_host_inst.poll(1, CODE_CLEAR, 1'b0, d);
    chk("stop cancel", d, {CODE_CLEAR, i_axis_state_register});
    i_link_no_station <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    ans(0, {CODE_CLEAR, i_axis_state_register});
    i_link_no_station <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    ans(2, {4{CODE_LINE}});
    mbxwn_host_inst.cancel(CODE_LINE, 2);
    mbxwn_host_inst.poll(0, CODE_CLEAR, 1'b0, d);
    chk("line cancel", d, {CODE_CLEAR, i_axis_state_register});
    i_link_no_station <= 1'b1;
    rst(6'h04, 6'h08, 1'b1);
    i_link_no_station <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    mbxwn_host_inst.rd(ADDR_STATUS, d, r);
    chk("warn", 32'(d[1:0]), 32'h1);
    mbxwn_host_inst.cancel(CODE_RESET, 2);
    repeat (40) @(posedge i_core_clk);
    ans(3, {4{CODE_RESET}});
    mbxwn_host_inst.cancel(CODE_RESET, 4);
    mbxwn_host_inst.poll(0, CODE_CLEAR, 1'b0, d);
    chk("ext cancel", d, {CODE_CLEAR, i_axis_state_register});
    order(4);
    stop_test();
  end
endmodule // tb
`default_nettype wire
